// file: mrs_pkg.sv
package mrs_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SEC_TIME_NS = 1_000_000_000;
	localparam int SEC_CYCLES = SEC_TIME_NS / CLK_PERIOD_NS;
	localparam int BAUD_SLOWEST = 1200;
	localparam int BIT_CYCLES_SLOWEST = CLK_HZ / BAUD_SLOWEST;
	// Select 0..4 gives 1200..19200 baud
	localparam logic [2:0] BAUD_MAX_SEL = 3'h4;
	localparam logic [7:0] IDLE_CHARS = 8'h03;
	localparam int PARAM_SLOTS = 10;
	localparam logic [3:0] PARAMS_MAX = 4'(PARAM_SLOTS);
	localparam logic [7:0] ADDR_BROADCAST = 8'h00;
	localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam logic [3:0] REQ_MIN_LEN = 4'h4;
	localparam logic [3:0] CNT_SAT = 4'hF;
	localparam logic [15:0] QTY_MAX = 16'h0014;
	localparam logic [5:0] RESP_OVERHEAD = 6'h05;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] TURB_WARM_S = 16'h0032;
	// Printed register map is one-based; wire numbers subtract the base
	localparam logic [7:0] MAP_BASE = 8'h01;
	localparam logic [7:0] MEAS_SLOT_OFS [PARAM_SLOTS] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09,
		8'h0B, 8'h0D, 8'h0F, 8'h11, 8'h13};
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	typedef struct packed {
		logic [7:0] slave_addr;
		logic [2:0] baud_sel;
		logic data8;
		logic stop2;
		logic [1:0] parity;
	} mrs_link_cfg_t;
	typedef logic [PARAM_SLOTS-1:0][31:0] mrs_values_t;
	typedef enum logic [2:0] {U_IDLE = 3'b000, U_START = 3'b001, U_DATA = 3'b010,
		U_PAR = 3'b011, U_STOP = 3'b100} mrs_uart_st_t;
	typedef enum logic [1:0] {S_RX = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b10} mrs_srv_st_t;
	typedef enum logic {M_SLEEP = 1'b0, M_WARM = 1'b1} mrs_meas_st_t;
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc16_byte
endpackage : mrs_pkg

// file: mrs_uart.sv
`timescale 1ns/1ps
module mrs_uart #(
	parameter int BIT_CYC = mrs_pkg::BIT_CYCLES_SLOWEST
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire mrs_pkg::mrs_link_cfg_t cfg_in,
	input wire logic rxd_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_err_out,
	output logic frame_end_out,
	input wire logic tx_start_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_busy_out,
	output logic txd_out
);
	import mrs_pkg::*;
	function automatic logic par_bit(input logic [7:0] d, input mrs_link_cfg_t c);
		logic p;
		p = c.data8 ? ^d : ^d[6:0];
		return (c.parity == PAR_ODD) ? ~p : p;
	endfunction : par_bit
	logic [15:0] blen;
	logic [3:0] last_bit;
	logic [7:0] idle_need;
	assign blen = 16'(BIT_CYC >> ((cfg_in.baud_sel > BAUD_MAX_SEL) ? BAUD_MAX_SEL : cfg_in.baud_sel));
	assign last_bit = cfg_in.data8 ? 4'h7 : 4'h6;
	// Start, data, parity and stop bits make one character time
	assign idle_need = IDLE_CHARS * (8'h03 + {4'h0, last_bit} + {7'h00, cfg_in.parity != PAR_NONE}
		+ {7'h00, cfg_in.stop2});
	////////////////////////////////////////////////////////////
	mrs_uart_st_t rx_st;
	logic [15:0] rx_cnt;
	logic [3:0] rx_bits;
	logic [7:0] rx_sh;
	logic rx_bad;
	logic [7:0] idle_bits;
	logic armed;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_st <= U_IDLE;
			rx_cnt <= 16'h0000;
			rx_bits <= 4'h0;
			rx_sh <= 8'h00;
			rx_bad <= 1'b0;
			idle_bits <= 8'h00;
			armed <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h00;
			rx_err_out <= 1'b0;
			frame_end_out <= 1'b0;
		end else begin
			rx_valid_out <= 1'b0;
			frame_end_out <= 1'b0;
			unique case (rx_st)
				U_IDLE: if (!rxd_in) begin
					rx_st <= U_START;
					rx_cnt <= blen >> 1;
					idle_bits <= 8'h00;
				end else if (rx_cnt == 16'h0000) begin
					rx_cnt <= blen - 16'h0001;
					idle_bits <= idle_bits + 8'h01;
					// Silence of three characters closes the frame
					if (armed && (idle_bits + 8'h01 >= idle_need)) begin //RULE8
						frame_end_out <= 1'b1;
						armed <= 1'b0;
					end
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				U_START: if (rx_cnt == 16'h0000) begin
					rx_st <= rxd_in ? U_IDLE : U_DATA;
					rx_cnt <= blen - 16'h0001;
					rx_bits <= 4'h0;
					rx_sh <= 8'h00;
					rx_bad <= 1'b0;
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				U_DATA: if (rx_cnt == 16'h0000) begin
					rx_cnt <= blen - 16'h0001;
					rx_sh <= {rx_sh[6:0], rxd_in}; //RULE19
					rx_bits <= rx_bits + 4'h1;
					if (rx_bits == last_bit) begin
						rx_st <= (cfg_in.parity != PAR_NONE) ? U_PAR : U_STOP;
					end
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				U_PAR: if (rx_cnt == 16'h0000) begin
					rx_cnt <= blen - 16'h0001;
					rx_bad <= rxd_in != par_bit(rx_sh, cfg_in); //RULE22
					rx_st <= U_STOP;
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				U_STOP: if (rx_cnt == 16'h0000) begin
					rx_cnt <= blen - 16'h0001;
					rx_valid_out <= 1'b1;
					rx_data_out <= rx_sh;
					rx_err_out <= rx_bad | !rxd_in;
					armed <= 1'b1;
					rx_st <= U_IDLE;
				end else begin
					rx_cnt <= rx_cnt - 16'h0001;
				end
				default: rx_st <= U_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////
	mrs_uart_st_t tx_st;
	logic [15:0] tx_cnt;
	logic [3:0] tx_bits;
	logic [7:0] tx_sh;
	logic tx_par;
	assign tx_busy_out = tx_st != U_IDLE;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_st <= U_IDLE;
			tx_cnt <= 16'h0000;
			tx_bits <= 4'h0;
			tx_sh <= 8'h00;
			tx_par <= 1'b0;
			txd_out <= 1'b1;
		end else if (tx_st == U_IDLE) begin
			if (tx_start_in) begin
				tx_sh <= cfg_in.data8 ? tx_data_in : {tx_data_in[6:0], 1'b0};
				tx_par <= par_bit(tx_data_in, cfg_in);
				tx_cnt <= blen - 16'h0001;
				txd_out <= 1'b0;
				tx_st <= U_START;
			end
		end else if (tx_cnt != 16'h0000) begin
			tx_cnt <= tx_cnt - 16'h0001;
		end else begin
			tx_cnt <= blen - 16'h0001;
			unique case (tx_st)
				U_START: begin
					txd_out <= tx_sh[7]; //RULE19
					tx_sh <= tx_sh << 1;
					tx_bits <= 4'h0;
					tx_st <= U_DATA;
				end
				U_DATA: if (tx_bits == last_bit) begin
					tx_bits <= 4'h0;
					txd_out <= (cfg_in.parity != PAR_NONE) ? tx_par : 1'b1;
					tx_st <= (cfg_in.parity != PAR_NONE) ? U_PAR : U_STOP;
				end else begin
					txd_out <= tx_sh[7];
					tx_sh <= tx_sh << 1;
					tx_bits <= tx_bits + 4'h1;
				end
				U_PAR: begin
					txd_out <= 1'b1;
					tx_st <= U_STOP;
				end
				U_STOP: if (cfg_in.stop2 && tx_bits == 4'h0) begin
					tx_bits <= 4'h1;
				end else begin
					tx_st <= U_IDLE;
				end
				default: tx_st <= U_IDLE;
			endcase
		end
	end
endmodule : mrs_uart

// file: mrs_slave.sv
`timescale 1ns/1ps
// How it works
// RULE1 - Transmit only in reply to a request
// RULE2 - One slave address per module
// RULE3 - Load values only after full warm-up
// RULE4 - Warm-up is longest sensor, turbidity 50s
// RULE5 - Active log warm-up overrides derived value
// RULE6 - Refresh all values at sample rate
// RULE7 - Binary framing, standard messages only
// RULE8 - Three character times idle ends frame
// RULE9 - Address, function, payload, CRC16 frame layout
// RULE10 - Master sends direct or broadcast address
// RULE11 - Reply echoes the request address
// RULE12 - Errors set function top bit, one code
// RULE13 - CRC covers all bytes before it
// RULE14 - Function follows address; only 03 served
// RULE15 - Two registers per parameter, from zero
// RULE16 - Request is eight bytes, count 2-20 (code accepts a count of 1-20)
// RULE17 - Reply is 5+N bytes, count doubled
// RULE18 - Each value is one 32-bit float
// RULE19 - Low register first, high byte first
// RULE20 - Serial side stays alive while probe sleeps
// RULE21 - Ignore requests while configuration USB attached
// RULE22 - Address, baud, bits, stop, parity configurable
// RULE23 - At most ten parameters configured
// RULE24 - Drop bad CRC, foreign address, broadcast
// RULE25 - Bad function or range gets exception
module mrs_slave #(
	parameter int SEC_CYC = mrs_pkg::SEC_CYCLES,
	parameter int BIT_CYC = mrs_pkg::BIT_CYCLES_SLOWEST
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic RXD_IN,
	output logic TXD_OUT,
	output logic TX_EN_OUT,
	input wire logic USB_ATTACHED_IN,
	input wire mrs_pkg::mrs_link_cfg_t LINK_CFG_IN,
	input wire logic [3:0] PARAM_COUNT_IN,
	input wire logic [15:0] SAMPLE_PERIOD_S_IN,
	input wire logic [15:0] SENSOR_WARM_S_IN,
	input wire logic TURBIDITY_PRESENT_IN,
	input wire logic LOG_ACTIVE_IN,
	input wire logic [15:0] LOG_WARM_S_IN,
	input wire mrs_pkg::mrs_values_t PROBE_DATA_IN,
	output logic PROBE_WAKE_OUT,
	output logic VALUES_LOADED_OUT
);
	import mrs_pkg::*;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_err;
	logic frame_end;
	logic tx_start_reg;
	logic [7:0] tx_byte_reg;
	logic tx_busy;
	// Link logic has no tie to the probe power state
	mrs_uart #(.BIT_CYC(BIT_CYC)) u_uart ( //RULE20
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.cfg_in(LINK_CFG_IN),
		.rxd_in(RXD_IN),
		.rx_valid_out(rx_valid),
		.rx_data_out(rx_data),
		.rx_err_out(rx_err),
		.frame_end_out(frame_end),
		.tx_start_in(tx_start_reg),
		.tx_data_in(tx_byte_reg),
		.tx_busy_out(tx_busy),
		.txd_out(TXD_OUT)
	);
	////////////////////////////////////////////////////////////
	// Probe warm-up and sampling
	mrs_meas_st_t meas_st;
	logic [31:0] cyc_reg;
	logic [15:0] secs_reg;
	logic [15:0] warm_target;
	logic [15:0] period;
	logic [31:0] hold_reg [PARAM_SLOTS];
	always_comb begin
		if (LOG_ACTIVE_IN) begin
			warm_target = LOG_WARM_S_IN; //RULE5
		end else if (TURBIDITY_PRESENT_IN && SENSOR_WARM_S_IN < TURB_WARM_S) begin
			warm_target = TURB_WARM_S; //RULE4
		end else begin
			warm_target = SENSOR_WARM_S_IN; //RULE4
		end
	end
	assign period = (SAMPLE_PERIOD_S_IN == 16'h0000) ? 16'h0001 : SAMPLE_PERIOD_S_IN;
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			meas_st <= M_WARM;
			cyc_reg <= 32'h0000_0000;
			secs_reg <= 16'h0000;
			PROBE_WAKE_OUT <= 1'b1;
			VALUES_LOADED_OUT <= 1'b0;
		end else if (cyc_reg != 32'(SEC_CYC - 1)) begin
			cyc_reg <= cyc_reg + 32'h0000_0001;
		end else begin
			// Whole seconds only, counted from the state change
			cyc_reg <= 32'h0000_0000;
			secs_reg <= secs_reg + 16'h0001;
			unique case (meas_st)
				M_WARM: if (secs_reg + 16'h0001 >= warm_target) begin //RULE3
					meas_st <= M_SLEEP;
					secs_reg <= 16'h0000;
					PROBE_WAKE_OUT <= 1'b0;
					VALUES_LOADED_OUT <= 1'b1;
				end
				M_SLEEP: if (secs_reg + 16'h0001 >= period) begin //RULE6
					meas_st <= M_WARM;
					secs_reg <= 16'h0000;
					PROBE_WAKE_OUT <= 1'b1;
				end
			endcase
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			for (int i = 0; i < PARAM_SLOTS; i++) begin
				hold_reg[i] <= 32'h0000_0000;
			end
		end else if (meas_st == M_WARM && cyc_reg == 32'(SEC_CYC - 1)
			&& secs_reg + 16'h0001 >= warm_target) begin
			for (int i = 0; i < PARAM_SLOTS; i++) begin
				hold_reg[i] <= PROBE_DATA_IN[i]; //RULE3 RULE6 RULE18
			end
		end
	end
	////////////////////////////////////////////////////////////
	// Request capture
	mrs_srv_st_t srv_st;
	logic [7:0] req_buf [8];
	logic [3:0] req_cnt;
	logic [15:0] req_crc;
	logic req_bad;
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			for (int i = 0; i < 8; i++) begin
				req_buf[i] <= 8'h00;
			end
			req_cnt <= 4'h0;
			req_crc <= CRC_INIT;
			req_bad <= 1'b0;
		end else if (frame_end) begin
			req_cnt <= 4'h0;
			req_crc <= CRC_INIT;
			req_bad <= 1'b0;
		end else if (rx_valid && srv_st == S_RX) begin
			if (req_cnt < REQ_LEN) begin
				req_buf[req_cnt[2:0]] <= rx_data; //RULE9
			end
			if (req_cnt != CNT_SAT) begin
				req_cnt <= req_cnt + 4'h1;
			end
			// Running over the CRC bytes too leaves zero when intact
			req_crc <= crc16_byte(req_crc, rx_data); //RULE13
			req_bad <= req_bad | rx_err | USB_ATTACHED_IN; //RULE21
		end
	end
	logic [15:0] req_start;
	logic [15:0] req_qty;
	logic [3:0] param_n;
	logic frame_ok;
	logic [7:0] exc_code;
	assign req_start = {req_buf[2], req_buf[3]};
	assign req_qty = {req_buf[4], req_buf[5]};
	assign param_n = (PARAM_COUNT_IN > PARAMS_MAX) ? PARAMS_MAX : PARAM_COUNT_IN; //RULE23
	assign frame_ok = frame_end && srv_st == S_RX && !req_bad && !USB_ATTACHED_IN //RULE21
		&& req_cnt >= REQ_MIN_LEN && req_crc == 16'h0000 //RULE24
		&& req_buf[0] == LINK_CFG_IN.slave_addr && req_buf[0] != ADDR_BROADCAST; //RULE2 RULE10
	always_comb begin
		exc_code = 8'h00;
		if (req_buf[1] != FUNC_READ_HOLD) begin
			exc_code = EXC_BAD_FUNC; //RULE7 RULE14 RULE25
		end else if (req_cnt != REQ_LEN || req_qty == 16'h0000 || req_qty > QTY_MAX) begin
			exc_code = EXC_BAD_VALUE; //RULE16
		end else if ({1'b0, req_start} + {1'b0, req_qty} > {12'h000, param_n, 1'b0}) begin
			exc_code = EXC_BAD_ADDR; //RULE25
		end
	end
	////////////////////////////////////////////////////////////
	// Response build and send
	logic [7:0] resp_addr;
	logic [7:0] resp_func;
	logic [7:0] resp_code;
	logic resp_exc;
	logic [15:0] resp_start;
	logic [5:0] resp_len;
	logic [5:0] idx;
	logic [15:0] tx_crc;
	logic [7:0] byte_next;
	logic [5:0] k;
	logic [15:0] reg_no;
	logic [31:0] pair;
	logic [15:0] word;
	always_comb begin
		k = idx - 6'h03;
		reg_no = resp_start + {11'h000, k[5:1]};
		pair = 32'h0000_0000;
		for (int i = 0; i < PARAM_SLOTS; i++) begin
			if ({reg_no[7:1], 1'b0} == MEAS_SLOT_OFS[i] - MAP_BASE) begin
				pair = hold_reg[i]; //RULE15
			end
		end
		// Low register carries the low half of the float
		word = reg_no[0] ? pair[31:16] : pair[15:0]; //RULE19
		if (idx == 6'h00) begin
			byte_next = resp_addr; //RULE11
		end else if (idx == 6'h01) begin
			byte_next = resp_exc ? (resp_func | EXC_FLAG) : resp_func; //RULE12
		end else if (idx == 6'h02) begin
			byte_next = resp_code; //RULE12 RULE17
		end else if (idx == resp_len - 6'h02) begin
			byte_next = tx_crc[7:0]; //RULE13
		end else if (idx == resp_len - 6'h01) begin
			byte_next = tx_crc[15:8];
		end else begin
			byte_next = k[0] ? word[7:0] : word[15:8]; //RULE19
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			srv_st <= S_RX;
			resp_addr <= 8'h00;
			resp_func <= 8'h00;
			resp_code <= 8'h00;
			resp_exc <= 1'b0;
			resp_start <= 16'h0000;
			resp_len <= 6'h00;
			idx <= 6'h00;
			tx_crc <= CRC_INIT;
			tx_start_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			TX_EN_OUT <= 1'b0;
		end else begin
			tx_start_reg <= 1'b0;
			unique case (srv_st)
				S_RX: if (frame_ok) begin //RULE1
					resp_addr <= req_buf[0];
					resp_func <= req_buf[1];
					resp_exc <= exc_code != 8'h00;
					resp_code <= (exc_code != 8'h00) ? exc_code : {req_qty[6:0], 1'b0};
					resp_start <= req_start;
					resp_len <= (exc_code != 8'h00) ? RESP_OVERHEAD
						: RESP_OVERHEAD + {req_qty[4:0], 1'b0}; //RULE17
					idx <= 6'h00;
					tx_crc <= CRC_INIT;
					TX_EN_OUT <= 1'b1;
					srv_st <= S_ISSUE;
				end
				S_ISSUE: begin
					tx_start_reg <= 1'b1;
					tx_byte_reg <= byte_next;
					if (idx < resp_len - 6'h02) begin
						tx_crc <= crc16_byte(tx_crc, byte_next); //RULE13
					end
					srv_st <= S_WAIT;
				end
				S_WAIT: if (!tx_busy && !tx_start_reg) begin
					if (idx == resp_len - 6'h01) begin
						TX_EN_OUT <= 1'b0;
						srv_st <= S_RX;
					end else begin
						idx <= idx + 6'h01;
						srv_st <= S_ISSUE;
					end
				end
				default: srv_st <= S_RX;
			endcase
		end
	end
	////////////////////////////////////////////////////////////
	// Checks
	logic [39:0] ph_cyc;
	logic wake_d;
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ph_cyc <= 40'h00_0000_0000;
			wake_d <= 1'b1;
		end else begin
			wake_d <= PROBE_WAKE_OUT;
			ph_cyc <= (wake_d != PROBE_WAKE_OUT) ? 40'h00_0000_0001 : ph_cyc + 40'h00_0000_0001;
		end
	end
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	chk_reply_cause: assert property ($rose(TX_EN_OUT) |-> $past(frame_end)) //RULE1
		else $error("Transmit began without a closed request");
	chk_quiet_idle: assert property (srv_st == S_RX |-> !tx_start_reg && !TX_EN_OUT) //RULE1
		else $error("Byte sent while listening");
	chk_usb_mute: assert property (frame_end && USB_ATTACHED_IN |=> !TX_EN_OUT) //RULE21
		else $error("Reply while USB attached");
	chk_bcast_mute: assert property (frame_end && req_buf[0] != LINK_CFG_IN.slave_addr //RULE24
		|=> !TX_EN_OUT)
		else $error("Reply to broadcast or foreign address");
	chk_own_addr: assert property (tx_start_reg && idx == 6'h00 //RULE11
		|-> tx_byte_reg == LINK_CFG_IN.slave_addr)
		else $error("Reply address differs from own");
	chk_exc_func: assert property (tx_start_reg && idx == 6'h01 && resp_exc //RULE12
		|-> tx_byte_reg[7] && resp_len == RESP_OVERHEAD)
		else $error("Exception frame malformed");
	chk_byte_count: assert property (tx_start_reg && idx == 6'h02 && !resp_exc //RULE17
		|-> {2'b00, tx_byte_reg[5:0]} + 8'h05 == {2'b00, resp_len})
		else $error("Byte count disagrees with length");
	// At the first sleeping edge the phase counter spans the whole wake phase
	chk_warm_full: assert property ($fell(PROBE_WAKE_OUT) //RULE3
		|-> ph_cyc >= 40'($past(warm_target)) * 40'(SEC_CYC))
		else $error("Values loaded before warm-up ended");
	chk_turb_floor: assert property ($fell(PROBE_WAKE_OUT) && $past(TURBIDITY_PRESENT_IN) //RULE4
		&& !$past(LOG_ACTIVE_IN) |-> ph_cyc >= 40'(TURB_WARM_S) * 40'(SEC_CYC))
		else $error("Turbidity warm-up too short");
	chk_log_warm: assert property ($fell(PROBE_WAKE_OUT) && $past(LOG_ACTIVE_IN) //RULE5
		|-> ph_cyc <= (40'($past(LOG_WARM_S_IN)) + 40'h00_0000_0001) * 40'(SEC_CYC))
		else $error("Log warm-up not applied");
	chk_sample_gap: assert property ($rose(PROBE_WAKE_OUT) //RULE6
		|-> ph_cyc >= 40'($past(period)) * 40'(SEC_CYC))
		else $error("Refresh came early");
	chk_idle_high: assert property (!TX_EN_OUT //RULE1
		|-> TXD_OUT)
		else $error("Line not idle high while silent");
	chk_en_span: assert property (tx_start_reg || tx_busy //RULE1
		|-> TX_EN_OUT)
		else $error("Byte sent outside the driver window");
	chk_one_slave: assert property ($rose(TX_EN_OUT) //RULE2
		|-> req_buf[0] == LINK_CFG_IN.slave_addr && req_buf[0] != ADDR_BROADCAST)
		else $error("Reply for an address not our own");
	chk_loaded_keep: assert property (VALUES_LOADED_OUT //RULE3
		|=> VALUES_LOADED_OUT)
		else $error("Loaded flag dropped");
	chk_sleep_loaded: assert property (!PROBE_WAKE_OUT //RULE3
		|-> VALUES_LOADED_OUT)
		else $error("Probe asleep before first load");
	chk_exc_range: assert property (tx_start_reg && idx == 6'h02 && resp_exc //RULE12
		|-> tx_byte_reg != 8'h00)
		else $error("Exception code zero");
	chk_count_limit: assert property (tx_start_reg && idx == 6'h02 && !resp_exc //RULE17
		|-> tx_byte_reg <= {QTY_MAX[6:0], 1'b0} && !tx_byte_reg[0])
		else $error("Byte count out of range");
	chk_usb_hold: assert property (USB_ATTACHED_IN && srv_st == S_RX //RULE21
		|=> srv_st == S_RX)
		else $error("Reply started while USB attached");
	cov_data_reply: cover property (tx_start_reg && idx == 6'h02 && !resp_exc);
	cov_exc_reply: cover property (tx_start_reg && idx == 6'h01 && resp_exc);
	cov_load: cover property ($fell(PROBE_WAKE_OUT));
	cov_refresh: cover property ($rose(PROBE_WAKE_OUT) && VALUES_LOADED_OUT);
endmodule : mrs_slave

// file: mrs_master_model.sv
`timescale 1ns/1ps
module mrs_master_model #(
	parameter int BIT = 4
) (
	input wire logic clk_in,
	input wire logic txd_in,
	input wire logic tx_en_in,
	output logic rxd_out
);
	logic [7:0] rx_q [$];
	logic [7:0] b;
	logic pbad;
	// Parity 0 none, 1 odd, 2 even; set by the bench together with the slave
	int par_mode = 0;
	int stops = 1;
	initial rxd_out = 1'b1;
	////////////////////////////////////////////////////////////
	// Bytes back to back, 8 data bits MSB first; line idles high after
	task automatic send(input logic [7:0] q [$]);
		logic [11:0] f;
		foreach (q[i]) begin
			f = (par_mode != 0) ? {1'b0, q[i], ^q[i] ^ (par_mode == 1), 2'b11} : {1'b0, q[i], 3'b111};
			for (int k = 0; k < ((par_mode != 0) ? 10 : 9) + stops; k++) begin
				@(negedge clk_in);
				rxd_out <= f[11 - k];
				repeat (BIT - 1) @(negedge clk_in);
			end
		end
		repeat (BIT) @(negedge clk_in);
	endtask : send
	////////////////////////////////////////////////////////////
	// Sampled at negedge so the slave's own register edge never races
	always begin
		@(negedge txd_in iff tx_en_in);
		repeat (BIT / 2) @(negedge clk_in);
		for (int k = 0; k < 8; k++) begin
			repeat (BIT) @(negedge clk_in);
			b[7 - k] = txd_in;
		end
		pbad = 1'b0;
		if (par_mode != 0) begin
			repeat (BIT) @(negedge clk_in);
			pbad = txd_in !== (^b ^ (par_mode == 1));
		end
		repeat (BIT) @(negedge clk_in);
		rx_q.push_back((txd_in === 1'b1 && !pbad) ? b : 8'hxx);
	end
endmodule : mrs_master_model

// file: mrs_slave_tb.sv
`timescale 1ns/1ps
module mrs_slave_tb;
	import mrs_pkg::*;
	localparam int SEC = 20;
	localparam int BITC = 4;
	localparam logic [7:0] ADDR = 8'h2A;
	logic clk, rst_n, usb, turb, log_act, txd, tx_en, rxd, wake, loaded;
	mrs_link_cfg_t cfg;
	logic [3:0] pcount;
	logic [15:0] period, swarm, lwarm;
	mrs_values_t pdata;
	logic [7:0] exp_q [$];
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	mrs_slave #(.SEC_CYC(SEC), .BIT_CYC(64)) i_mrs_slave (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .RXD_IN(rxd),
		.TXD_OUT(txd), .TX_EN_OUT(tx_en), .USB_ATTACHED_IN(usb), .LINK_CFG_IN(cfg), .PARAM_COUNT_IN(pcount),
		.SAMPLE_PERIOD_S_IN(period), .SENSOR_WARM_S_IN(swarm), .TURBIDITY_PRESENT_IN(turb),
		.LOG_ACTIVE_IN(log_act), .LOG_WARM_S_IN(lwarm), .PROBE_DATA_IN(pdata), .PROBE_WAKE_OUT(wake),
		.VALUES_LOADED_OUT(loaded));
	mrs_master_model #(.BIT(BITC)) i_mrs_master_model (.clk_in(clk), .txd_in(txd), .tx_en_in(tx_en),
		.rxd_out(rxd));
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Ceiling well above the longest expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc(input logic [7:0] q [$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("Checks made %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	// Reset, then time the first load from release
	task automatic warm(input int secs);
		int n;
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		check({txd, tx_en, wake, loaded}, 32'h0000_000A);
		rst_n = 1'b1;
		n = 0;
		while (loaded !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check(32'((n >= secs * SEC - 2) && (n <= secs * SEC + 3)), 1);
		check(32'(wake), 0);
		// Let the load edge be checked before any new reset
		repeat (2) @(negedge clk);
	endtask : warm
	// Request with good or spoiled CRC; reply compared against exp_q
	task automatic xfer(input logic [7:0] a, input logic [7:0] f, input logic [15:0] s, input logic [15:0] n,
		input logic bad);
		logic [15:0] c;
		logic [7:0] req [$];
		req = '{a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
		c = crc(req) ^ {15'h0000, bad};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		i_mrs_master_model.rx_q.delete();
		i_mrs_master_model.send(req);
		for (int i = 0; i < 400 && tx_en !== 1'b1; i++) @(negedge clk);
		for (int i = 0; i < 4000 && tx_en !== 1'b0; i++) @(negedge clk);
		repeat (2 * BITC) @(negedge clk);
		if (exp_q.size() > 0) begin
			c = crc(exp_q);
			exp_q.push_back(c[7:0]);
			exp_q.push_back(c[15:8]);
		end
		check(32'(i_mrs_master_model.rx_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) begin
			if (i < i_mrs_master_model.rx_q.size()) check(32'(i_mrs_master_model.rx_q[i]), 32'(exp_q[i]));
		end
	endtask : xfer
	task automatic read_ok(input logic [15:0] s, input logic [15:0] n);
		logic [15:0] w;
		exp_q = '{ADDR, FUNC_READ_HOLD, 8'(2 * n)};
		for (int r = s; r < s + n; r++) begin
			w = r[0] ? pdata[r >> 1][31:16] : pdata[r >> 1][15:0];
			exp_q.push_back(w[15:8]);
			exp_q.push_back(w[7:0]);
		end
		xfer(ADDR, FUNC_READ_HOLD, s, n, 1'b0);
	endtask : read_ok
	task automatic exc(input logic [7:0] f, input logic [15:0] s, input logic [15:0] n, input logic [7:0] code);
		exp_q = '{ADDR, f | 8'h80, code};
		xfer(ADDR, f, s, n, 1'b0);
	endtask : exc
	task automatic silent(input logic [7:0] a, input logic bad);
		exp_q.delete();
		xfer(a, FUNC_READ_HOLD, 0, 2, bad);
	endtask : silent
	////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		{usb, turb, log_act} = 3'b010;
		swarm = 16'h0003;
		lwarm = 16'h0004;
		period = 16'h0002;
		pcount = 4'hA;
		cfg = '{ADDR, 3'h4, 1'b1, 1'b0, PAR_NONE};
		for (int i = 0; i < PARAM_SLOTS; i++) begin
			pdata[i] = 32'h3FC7_AE14 + 32'(i) * 32'h0101_0101;
		end
		warm(50);
		log_act = 1'b1;
		warm(4);
		{turb, log_act} = 2'b00;
		warm(3);
		read_ok(0, 2);
		read_ok(0, 20);
		read_ok(9, 3);
		exc(8'h04, 0, 2, 8'h01);
		exc(FUNC_READ_HOLD, 0, 0, 8'h03);
		exc(FUNC_READ_HOLD, 0, 21, 8'h03);
		pcount = 4'h3;
		read_ok(4, 2);
		exc(FUNC_READ_HOLD, 4, 4, 8'h02);
		silent(ADDR, 1'b1);
		silent(8'h2B, 1'b0);
		silent(ADDR_BROADCAST, 1'b0);
		usb = 1'b1;
		silent(ADDR, 1'b0);
		usb = 1'b0;
		pdata[0] = 32'h4049_0FDB;
		for (int i = 0; i < 300 && wake !== 1'b1; i++) @(negedge clk);
		for (int i = 0; i < 300 && wake !== 1'b0; i++) @(negedge clk);
		check(32'(wake), 0);
		read_ok(0, 2);
		cfg.parity = PAR_ODD;
		cfg.stop2 = 1'b1;
		i_mrs_master_model.par_mode = 1;
		i_mrs_master_model.stops = 2;
		read_ok(2, 2);
		test_done();
	end
endmodule : mrs_slave_tb
